/* File: rtl/pod_reset_access.sv */
// Purpose: Emulator pod reset release, target reset drive, host access
//          width, emulation wait states and memory characterization
// Assumes: ref_clk is the double-rate input clock; inputs synchronous
//          except socketReset
// Notes:   Target reset drive is open collector: out is low, oe drives
`timescale 1ns/1ps
module pod_reset_access #(
  parameter int TERMS = 4
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdData,
  input  wire logic        socketReset,
  output logic             procReset,
  output logic             procClkPhase,
  output logic             targetResetDriveOut,
  output logic             targetResetDriveOe,
  input  wire logic [31:0] procAddr,
  input  wire logic        procStrobe,
  output logic      [2:0]  memChar,
  output logic      [7:0]  emuBlock,
  output logic             guardBreak,
  input  wire logic [2:0]  burstBeat,
  output logic      [1:0]  waitStates
);
  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Width in bytes of a size code
  function automatic logic [2:0] size_bytes(input logic [1:0] s);
    size_bytes = (s == pod_ctrl_pkg::SIZE_WORD)  ? 3'h4 :
                 (s == pod_ctrl_pkg::SIZE_SHORT) ? 3'h2 : 3'h1;
  endfunction
  // Smaller of two size codes
  function automatic logic [1:0] size_min(input logic [1:0] a,
                                          input logic [1:0] b);
    size_min = (a < b) ? a : b;
  endfunction
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]  cfg;
  logic [7:0]  accReq;
  logic [31:0] termLo   [TERMS];
  logic [31:0] termHi   [TERMS];
  logic [3:0]  termAttr [TERMS];
  logic        sockMeta;
  logic        sockSync;
  logic        driveOn;
  logic        procHeld;
  pod_ctrl_pkg::rel_t relState;
  pod_ctrl_pkg::rel_t next_relState;
  // Decoded configuration fields
  wire logic       waitMode = cfg[pod_ctrl_pkg::CFG_WAIT_BIT];
  wire logic       polHigh  = cfg[pod_ctrl_pkg::CFG_POL_BIT];
  wire logic       busFast  = cfg[pod_ctrl_pkg::CFG_FAST_BIT];
  wire logic       narrow   = cfg[pod_ctrl_pkg::CFG_NARR_BIT];
  wire logic [1:0] cfgSize  = cfg[pod_ctrl_pkg::CFG_SIZE_LSB +: 2];
  wire logic [1:0] defChar  = cfg[pod_ctrl_pkg::CFG_DEF_LSB +: 2];
  // Write decode
  wire logic wrCfg = regWrite && regAddr == pod_ctrl_pkg::CFG_OFS;
  wire logic wrCmd = regWrite && regAddr == pod_ctrl_pkg::CMD_OFS;
  wire logic wrAcc = regWrite && regAddr == pod_ctrl_pkg::ACCESS_OFS;
  wire logic cmdReset = wrCmd && regWrData[pod_ctrl_pkg::CMD_RESET_BIT];
  wire logic cmdRelease = wrCmd &&
    (regWrData[pod_ctrl_pkg::CMD_BREAK_BIT] ||
     regWrData[pod_ctrl_pkg::CMD_RUN_BIT] ||
     regWrData[pod_ctrl_pkg::CMD_INIT_BIT]);
  // Unmapped default may never name emulation memory
  wire logic defOk = regWrData[pod_ctrl_pkg::CFG_DEF_LSB +: 2] != 2'h3;
  // ----------------------------------------------------------------
  // Configuration and host access request registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cfg    <= pod_ctrl_pkg::CFG_RESET;
      accReq <= 8'h00;
    end
    else
    begin
      if (wrCfg)
      begin
        cfg[5:0] <= regWrData[5:0];
        if (defOk)
          cfg[7:6] <= regWrData[7:6];
      end
      if (wrAcc)
        accReq <= regWrData[7:0];
    end
  end
  // Mapper terms: lo, hi, attr {enable, type[2:0]}
  genvar t;
  generate
    for (t = 0; t < TERMS; t++)
    begin : g_term
      localparam logic [7:0] BASE = 8'(pod_ctrl_pkg::TERM_BASE_OFS +
                                       t * pod_ctrl_pkg::TERM_STRIDE);
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          termLo[t]   <= 32'h0000_0000;
          termHi[t]   <= 32'h0000_0000;
          termAttr[t] <= 4'h0;
        end
        else if (regWrite)
        begin
          if (regAddr == BASE + pod_ctrl_pkg::TERM_LO_OFS)
            termLo[t] <= regWrData;
          if (regAddr == BASE + pod_ctrl_pkg::TERM_HI_OFS)
            termHi[t] <= regWrData;
          if (regAddr == BASE + pod_ctrl_pkg::TERM_ATTR_OFS)
            termAttr[t] <= regWrData[3:0];
        end
      end
    end
  endgenerate
  // ----------------------------------------------------------------
  // Socket reset synchronizer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sockMeta <= 1'b0;
      sockSync <= 1'b0;
    end
    else
    begin
      sockMeta <= socketReset;
      sockSync <= sockMeta;
    end
  end
  // ----------------------------------------------------------------
  // Reset release state machine
  // ----------------------------------------------------------------
  always_comb
  begin
    next_relState = relState;
    if (cmdReset)
      next_relState = waitMode ? pod_ctrl_pkg::AWAIT_RESET
                               : pod_ctrl_pkg::AWAIT_RUN;
    else if (sockSync)
      next_relState = pod_ctrl_pkg::AWAIT_RUN;
    else
      case (relState)
        pod_ctrl_pkg::AWAIT_RESET:
          if (!waitMode)
            next_relState = pod_ctrl_pkg::RUNNING;
          else
            next_relState = pod_ctrl_pkg::AWAIT_RESET;
        pod_ctrl_pkg::AWAIT_RUN:
          next_relState = pod_ctrl_pkg::RUNNING;
        pod_ctrl_pkg::RUNNING:
          next_relState = pod_ctrl_pkg::RUNNING;
        default:
          next_relState = pod_ctrl_pkg::AWAIT_RESET;
      endcase
  end
  wire logic next_procHeld = next_relState != pod_ctrl_pkg::RUNNING;
  // State, processor reset and half-rate phase
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      relState     <= pod_ctrl_pkg::AWAIT_RESET;
      procHeld     <= 1'b1;
      procReset    <= 1'b1;
      procClkPhase <= 1'b0;
    end
    else
    begin
      relState  <= next_relState;
      procHeld  <= next_procHeld;
      procReset <= next_procHeld;
      // Phase is held at zero and goes to one on the cycle reset falls
      procClkPhase <= next_procHeld ? 1'b0 : ~procClkPhase;
    end
  end
  // ----------------------------------------------------------------
  // Target reset drive, open collector
  // ----------------------------------------------------------------
  // Asserted level: high polarity -> released (pulled up)
  wire logic next_driveOe = driveOn ? !polHigh : polHigh;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      driveOn             <= 1'b0;
      targetResetDriveOut <= 1'b0;
      targetResetDriveOe  <= 1'b0;
    end
    else
    begin
      if (cmdReset)
        driveOn <= 1'b1;
      else if (cmdRelease)
        driveOn <= 1'b0;
      targetResetDriveOut <= 1'b0;
      targetResetDriveOe  <= next_driveOe;
    end
  end
  // ----------------------------------------------------------------
  // Host access width and transfer count
  // ----------------------------------------------------------------
  wire logic [1:0] reqSize  = accReq[3:2];
  wire logic [1:0] reqAlign = accReq[1:0];
  wire logic [1:0] fitSize  = size_min(cfgSize, reqSize);
  // Alignment caps the width of each access
  wire logic [1:0] alnSize  = reqAlign[0] ? pod_ctrl_pkg::SIZE_BYTE :
                              reqAlign[1] ? pod_ctrl_pkg::SIZE_SHORT :
                                            pod_ctrl_pkg::SIZE_WORD;
  wire logic [1:0] effSize  = size_min(fitSize, alnSize);
  // Narrow bus carries a word as two shorts
  wire logic [1:0] busSize  = (narrow && effSize ==
                               pod_ctrl_pkg::SIZE_WORD)
                              ? pod_ctrl_pkg::SIZE_SHORT : effSize;
  wire logic [2:0] reqBytes = size_bytes(reqSize);
  wire logic [2:0] busBytes = size_bytes(busSize);
  wire logic [2:0] xferCnt  = (busBytes == 3'h1) ? reqBytes :
                              (busBytes == 3'h2) ? {1'b0, reqBytes[2:1]}
                                                 : 3'h1;
  wire logic       burst    = effSize == pod_ctrl_pkg::SIZE_WORD &&
                              narrow;
  // ----------------------------------------------------------------
  // Emulation memory wait states
  // ----------------------------------------------------------------
  wire logic first = burstBeat == 3'h0;
  wire logic [1:0] next_wait =
    narrow  ? {1'b0, busFast && first} :
    busFast ? (first ? 2'h2 : 2'h1) : 2'h1;
  // ----------------------------------------------------------------
  // Memory characterization and emulation block assignment
  // ----------------------------------------------------------------
  logic [2:0] hitChar;
  logic [7:0] hitBlock;
  logic       hit;
  always_comb
  begin
    logic [7:0] blk;
    blk      = 8'h00;
    hit      = 1'b0;
    hitChar  = {1'b0, defChar};
    hitBlock = 8'h00;
    for (int i = 0; i < TERMS; i++)
    begin
      if (termAttr[i][3] && !hit && procAddr >= termLo[i] &&
          procAddr <= termHi[i])
      begin
        hit      = 1'b1;
        hitChar  = termAttr[i][2:0];
        hitBlock = blk;
      end
      // Blocks pack onto enabled emulation terms in order
      if (termAttr[i][3] && termAttr[i][2:0] >= pod_ctrl_pkg::CHAR_ERAM)
        blk = blk + 8'h01;
    end
  end
  // Mapper outputs
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      memChar    <= pod_ctrl_pkg::CHAR_TRAM;
      emuBlock   <= 8'h00;
      guardBreak <= 1'b0;
      waitStates <= 2'h0;
    end
    else
    begin
      memChar    <= hitChar;
      emuBlock   <= hitBlock;
      guardBreak <= procStrobe && hitChar == pod_ctrl_pkg::CHAR_GUARD;
      waitStates <= next_wait;
    end
  end
  // ----------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------------------------------
  logic [31:0] rdMux;
  always_comb
  begin
    rdMux = 32'h0000_0000;
    case (regAddr)
      pod_ctrl_pkg::CFG_OFS:    rdMux = {24'h00_0000, cfg};
      pod_ctrl_pkg::STATUS_OFS:
        rdMux = {27'h000_0000, sockSync, driveOn, procHeld, relState};
      pod_ctrl_pkg::ACCESS_OFS:
        rdMux = {16'h0000, 4'h0, burst, xferCnt, 2'h0, busSize,
                 accReq[3:0]};
      default:
        for (int i = 0; i < TERMS; i++)
        begin
          if (regAddr == 8'(pod_ctrl_pkg::TERM_BASE_OFS + i *
                            pod_ctrl_pkg::TERM_STRIDE))
            rdMux = termLo[i];
          if (regAddr == 8'(pod_ctrl_pkg::TERM_BASE_OFS + i *
                            pod_ctrl_pkg::TERM_STRIDE + 4))
            rdMux = termHi[i];
          if (regAddr == 8'(pod_ctrl_pkg::TERM_BASE_OFS + i *
                            pod_ctrl_pkg::TERM_STRIDE + 8))
            rdMux = {28'h000_0000, termAttr[i]};
        end
    endcase
  end
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      regRdData <= 32'h0000_0000;
    else
      regRdData <= regRead ? rdMux : 32'h0000_0000;
  end
endmodule

/* File: inc/pod_ctrl_pkg.sv */
// Purpose: Constants for the emulator pod reset and access control
// Assumes: 32-bit register port, byte addresses
// Notes:   Mapper term registers repeat every TERM_STRIDE bytes
package pod_ctrl_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_OFS       = 8'h00;
  localparam logic [7:0] CMD_OFS       = 8'h04;
  localparam logic [7:0] STATUS_OFS    = 8'h08;
  localparam logic [7:0] ACCESS_OFS    = 8'h0C;
  localparam logic [7:0] TERM_BASE_OFS = 8'h10;
  localparam logic [7:0] TERM_STRIDE   = 8'h10;
  localparam logic [7:0] TERM_LO_OFS   = 8'h00;
  localparam logic [7:0] TERM_HI_OFS   = 8'h04;
  localparam logic [7:0] TERM_ATTR_OFS = 8'h08;
  // ----------------------------------------------------------------
  // Configuration fields and reset value
  // ----------------------------------------------------------------
  localparam int          CFG_WAIT_BIT = 0;
  localparam int          CFG_POL_BIT  = 1;
  localparam int          CFG_FAST_BIT = 2;
  localparam int          CFG_NARR_BIT = 3;
  localparam int          CFG_SIZE_LSB = 4;
  localparam int          CFG_DEF_LSB  = 6;
  localparam logic [7:0]  CFG_RESET    = 8'h01;
  // ----------------------------------------------------------------
  // Command bits (write pulses)
  // ----------------------------------------------------------------
  localparam int CMD_RESET_BIT = 0;
  localparam int CMD_BREAK_BIT = 1;
  localparam int CMD_RUN_BIT   = 2;
  localparam int CMD_INIT_BIT  = 3;
  // ----------------------------------------------------------------
  // Access sizes and memory characterizations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SIZE_BYTE  = 2'h0,
    SIZE_SHORT = 2'h1,
    SIZE_WORD  = 2'h2
  } size_t;
  typedef enum logic [2:0] {
    CHAR_TRAM  = 3'h0,
    CHAR_TROM  = 3'h1,
    CHAR_GUARD = 3'h2,
    CHAR_ERAM  = 3'h3,
    CHAR_EROM  = 3'h4
  } char_t;
  // Release states, Gray along the usual path
  typedef enum logic [1:0] {
    AWAIT_RESET = 2'b00,
    AWAIT_RUN   = 2'b01,
    RUNNING     = 2'b11
  } rel_t;
endpackage

/* File: bench/pod_ctrl_sva.sv */
// Purpose: Checker for pod reset release, drive, mapper and waits
// Assumes: Sees only the top module ports
// Notes:   Shadows the config register to predict wait states
`timescale 1ns/1ps
module pod_ctrl_sva (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWrData,
  input wire logic        regWrite,
  input wire logic        socketReset,
  input wire logic        procReset,
  input wire logic        procClkPhase,
  input wire logic        targetResetDriveOut,
  input wire logic        targetResetDriveOe,
  input wire logic        procStrobe,
  input wire logic [2:0]  memChar,
  input wire logic        guardBreak,
  input wire logic [2:0]  burstBeat,
  input wire logic [1:0]  waitStates
);
  logic [7:0] cfg;
  logic [1:0] expWait;
  logic [1:0] next_wait;
  // Register decodes and predicted wait count
  wire cmdWr = regWrite && regAddr == pod_ctrl_pkg::CMD_OFS;
  wire cfgWr = regWrite && regAddr == pod_ctrl_pkg::CFG_OFS;
  wire fastBeat0 = cfg[pod_ctrl_pkg::CFG_FAST_BIT] && burstBeat == 3'h0;
  wire polHigh = cfg[pod_ctrl_pkg::CFG_POL_BIT];
  assign next_wait = cfg[pod_ctrl_pkg::CFG_NARR_BIT] ? {1'b0, fastBeat0}
                   : (fastBeat0 ? 2'h2 : 2'h1);
  // Config shadow and wait prediction
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      cfg     <= pod_ctrl_pkg::CFG_RESET;
      expWait <= 2'h0;
    end
    else
    begin
      if (cfgWr)
        cfg <= regWrData[7:0];
      expWait <= next_wait;
    end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence sockHigh4;
    socketReset [*4];
  endsequence
  sequence resetCmd;
    cmdWr && regWrData[0] ##1 !cfgWr;
  endsequence
  sequence releaseCmd;
    cmdWr && !regWrData[0] && |regWrData[3:1] ##1 !cfgWr;
  endsequence
  a_high_holds: assert property (sockHigh4 |-> procReset)
    else $error("processor not held while socket reset high");
  a_release_low: assert property (
    $fell(procReset) |-> !$past(socketReset, 3))
    else $error("release without a settled low socket level");
  a_sync_delay: assert property (
    $fell(socketReset) && procReset |=> procReset [*2])
    else $error("release earlier than two sync stages allow");
  a_phase_held: assert property (procReset [*3] |-> !procClkPhase)
    else $error("clock phase moving while held");
  a_phase_toggle: assert property (
    !procReset [*2] |-> procClkPhase != $past(procClkPhase))
    else $error("clock phase not at half rate");
  a_out_low: assert property (!targetResetDriveOut)
    else $error("open collector output driven high");
  a_drive_assert: assert property (
    resetCmd |-> ##1 targetResetDriveOe != polHigh)
    else $error("reset drive not asserted after reset command");
  a_drive_release: assert property (
    releaseCmd |-> ##1 targetResetDriveOe == polHigh)
    else $error("reset drive not released after release command");
  a_guard_break: assert property (
    $past(procStrobe) |-> guardBreak ==
      (memChar == pod_ctrl_pkg::CHAR_GUARD))
    else $error("guard break does not match characterization");
  a_guard_cause: assert property (guardBreak |-> $past(procStrobe))
    else $error("guard break without a processor access");
  a_wait_states: assert property (waitStates == expWait)
    else $error("wrong emulation memory wait count");
endmodule
bind pod_reset_access pod_ctrl_sva i_pod_ctrl_sva (.ref_clk, .rst,
  .regAddr, .regWrData, .regWrite, .socketReset, .procReset,
  .procClkPhase, .targetResetDriveOut, .targetResetDriveOe, .procStrobe,
  .memChar, .guardBreak, .burstBeat, .waitStates);

/* File: bench/target_board.sv */
// Purpose: Target board reset circuitry facing the pod
// Assumes: Drive lead has a pull-up on the board
// Notes:   Lead may be left unconnected to test release alone
`timescale 1ns/1ps
module target_board (
  input  wire logic driveOe,
  input  wire logic polHigh,
  input  wire logic linked,
  input  wire logic manualReset,
  output logic      socketReset
);
  // Pull-up gives high unless the pod sinks the lead
  wire leadLevel = !driveOe;
  // Board reset from its own pulse or from an active lead
  assign socketReset = manualReset
                    || (linked && leadLevel == polHigh);
endmodule

/* File: bench/emulator_pod_reset_and_access_control_tb.sv */
// Purpose: Self-checking bench for the pod reset and access block
// Assumes: Register port with read data one cycle after the strobe
// Notes:   Socket reset comes from the target board model
`timescale 1ns/1ps
module emulator_pod_reset_and_access_control_tb;
  logic        ref_clk;
  logic        rst;
  logic        regWrite;
  logic        regRead;
  logic        procStrobe;
  logic        socketReset;
  logic        procReset;
  logic        procClkPhase;
  logic        driveOe;
  logic        guardBreak;
  logic        linked;
  logic        manualReset;
  logic [7:0]  regAddr;
  logic [7:0]  emuBlock;
  logic [31:0] regWrData;
  logic [31:0] regRdData;
  logic [31:0] procAddr;
  logic [31:0] d;
  logic [2:0]  memChar;
  logic [2:0]  burstBeat;
  logic [1:0]  waitStates;
  logic [1:0]  exp;
  int          fail_count;
  int          n_tests;
  pod_reset_access i_pod_reset_access (.ref_clk, .rst, .regAddr,
    .regWrData, .regWrite, .regRead, .regRdData, .socketReset, .procReset,
    .procClkPhase, .targetResetDriveOut(), .targetResetDriveOe(driveOe),
    .procAddr, .procStrobe, .memChar, .emuBlock, .guardBreak, .burstBeat,
    .waitStates);
  target_board i_target_board (.driveOe, .polHigh(1'b0), .linked,
    .manualReset, .socketReset);
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    regWrite  <= 1'b1;
    regAddr   <= a;
    regWrData <= v;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRead <= 1'b0;
    @(negedge ref_clk);
    d = regRdData;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic probe(input logic [31:0] a);
    @(posedge ref_clk);
    procAddr   <= a;
    procStrobe <= 1'b1;
    @(posedge ref_clk);
    procStrobe <= 1'b0;
    @(negedge ref_clk);
  endtask
  // Access width check: e is {burst, count, size}
  task automatic acc(input logic [7:0] c, input logic [3:0] a,
                     input logic [5:0] e);
    wr(8'h00, {24'h00_0000, c});
    wr(8'h0C, {28'h000_0000, a});
    rd(8'h0C);
    chk({d[11], d[10:8], d[5:4], d[3:0]}, {e, a});
  endtask
  task end_sim;
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Clock and watchdog
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    end_sim;
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    {regWrite, regRead, procStrobe, linked, manualReset} = 5'h00;
    regAddr = 8'h00;
    regWrData = 32'h0000_0000;
    procAddr = 32'h0000_0000;
    burstBeat = 3'h0;
    fail_count = 0;
    n_tests = 0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    rd(8'h00);
    chk(d, 32'h0000_0001);
    rd(8'hFC);
    chk(d, 32'h0000_0000);
    rd(8'h08);
    chk(d[2:0], 3'h4);
    @(posedge ref_clk) manualReset <= 1'b1;
    cyc(6);
    rd(8'h08);
    chk(d[2:0], 3'h5);
    @(posedge ref_clk) manualReset <= 1'b0;
    cyc(6);
    chk(procReset, 1'b0);
    d[0] = procClkPhase;
    cyc(1);
    chk(procClkPhase, !d[0]);
    $display("Test target pulse release done");
    @(posedge ref_clk) linked <= 1'b1;
    wr(8'h04, 32'h0000_0001);
    cyc(6);
    rd(8'h08);
    chk(d[3:0], 4'hD);
    wr(8'h04, 32'h0000_0004);
    cyc(8);
    chk({driveOe, procReset}, 2'h0);
    @(posedge ref_clk) linked <= 1'b0;
    wr(8'h04, 32'h0000_0001);
    cyc(6);
    rd(8'h08);
    chk(d[2:0], 3'h4);
    wr(8'h00, 32'h0000_0000);
    wr(8'h04, 32'h0000_0001);
    cyc(6);
    chk(procReset, 1'b0);
    $display("Test reset drive release done");
    for (int p = 0; p < 2; p++)
      for (int b = 1; b < 4; b++)
      begin
        wr(8'h00, 32'(p) << 1);
        wr(8'h04, 32'h0000_0003);
        cyc(2);
        chk(driveOe, 32'(p == 0));
        wr(8'h04, 32'h0000_0001 << b);
        cyc(2);
        chk(driveOe, 32'(p == 1));
      end
    $display("Test drive polarity done");
    wr(8'h00, 32'h0000_0000);
    probe(32'h0000_5000);
    chk({guardBreak, memChar}, 4'h0);
    wr(8'h00, 32'h0000_0080);
    probe(32'h0000_5000);
    chk({guardBreak, memChar}, 4'hA);
    wr(8'h00, 32'h0000_00C0);
    rd(8'h00);
    chk(d[7:6], 2'h2);
    wr(8'h10, 32'h0000_1000);
    wr(8'h14, 32'h0000_1FFF);
    wr(8'h18, 32'h0000_000B);
    wr(8'h20, 32'h0000_2000);
    wr(8'h24, 32'h0000_2FFF);
    wr(8'h28, 32'h0000_000B);
    probe(32'h0000_2800);
    chk({emuBlock, 1'b0, memChar}, 12'h013);
    wr(8'h18, 32'h0000_0003);
    probe(32'h0000_2800);
    chk({emuBlock, 1'b0, memChar}, 12'h003);
    probe(32'h0000_1800);
    chk({guardBreak, memChar}, 4'hA);
    $display("Test mapper done");
    acc(8'h20, 4'h8, 6'h06);
    acc(8'h28, 4'h8, 6'h29);
    acc(8'h00, 4'h8, 6'h10);
    acc(8'h10, 4'h8, 6'h09);
    acc(8'h20, 4'hA, 6'h09);
    acc(8'h20, 4'h1, 6'h04);
    $display("Test access width done");
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h00, 32'(c) << 2);
      for (int b = 0; b < (c > 1 ? 8 : 4); b++)
      begin
        @(posedge ref_clk) burstBeat <= 3'(b);
        cyc(1);
        exp = (c[0] && b == 0) ? 2'h2 : 2'h1;
        if (c > 1)
          exp = (c[0] && b == 0) ? 2'h1 : 2'h0;
        chk(waitStates, exp);
      end
    end
    @(posedge ref_clk) burstBeat <= 3'h0;
    $display("Test wait states done");
    end_sim;
  end
endmodule
